// ==== rtl/cie_defines.svh ====
// Constants for the instruction subset execution block
`ifndef CIE_DEFINES_SVH
`define CIE_DEFINES_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define CIE_DW 8
`define CIE_FA_W 5
`define CIE_PC_W 9
`define CIE_AW 6
`define CIE_NREG 32

// ----------------------------------------
// Register offsets on the software port
// ----------------------------------------
`define CIE_OFF_W 6'h00
`define CIE_OFF_OPT 6'h01
`define CIE_OFF_FLAGS 6'h02
`define CIE_OFF_EVT 6'h03
`define CIE_OFF_MASK 6'h04
`define CIE_OFF_WDT 6'h05
`define CIE_OFF_PRESC 6'h06
`define CIE_FILE_BIT 5

// ----------------------------------------
// Event bit positions
// ----------------------------------------
`define CIE_EV_SLEEP 0
`define CIE_EV_RET 1
`define CIE_EV_WDT 2
`define CIE_EV_DISC 3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CIE_RST_W 8'h00
`define CIE_RST_OPT 8'hff
`define CIE_RST_MASK 8'h00
`define CIE_RST_FLAGS 6'h18

// ----------------------------------------
// Watchdog limits
// ----------------------------------------
`define CIE_PRESC_MAX 8'hff
`define CIE_WDT_MAX 8'hff

`endif

// ==== rtl/cie_exec.sv ====
// Execution unit for a subset of an 8-bit core's instructions
//
// Overview of operation
// - Option load copies accumulator, flags untouched
// - Literal return puts literal in accumulator
// - Literal return loads PC from stack top
// - Literal return discards next fetched instruction
// - Sleep clears watchdog counter and prescaler
// - Sleep sets timeout, clears powerdown flag
// - Sleep halts execution, watchdog keeps counting
// - Rotate left through carry, carry only
// - Rotate right through carry, carry only
// - Destination bit selects accumulator or file
// - Subtract file minus accumulator, sets C DC Z
//
// Each valid instruction strobe while awake updates the registered state on the
// same edge; a literal return drops the next fetched instruction.
// Software reaches the state over a small register port whose read
// data follow the read strobe by one cycle. The watchdog prescaler
// runs on every clock and the counter on each prescaler rollover,
// also while the core is halted, so their overflow event still
// reaches the interrupt line. Events are
// sticky until their status register is read.
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`include "cie_defines.svh"

module cie_exec (
  input wire logic I_CLK_SYS,
  input wire logic I_RESET,
  input wire cie_pkg::cie_instr_s I_INSTR,
  input wire logic I_INSTR_VALID,
  input wire logic [`CIE_PC_W-1:0] I_STACK_TOP,
  input wire logic I_WAKE,
  input wire logic [`CIE_AW-1:0] I_ADDR,
  input wire logic [`CIE_DW-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [`CIE_DW-1:0] O_RDATA,
  output logic O_IRQ,
  output logic [`CIE_DW-1:0] O_W,
  output logic [`CIE_DW-1:0] O_OPTION,
  output cie_pkg::cie_flags_s O_FLAGS,
  output logic [`CIE_PC_W-1:0] O_PC,
  output logic O_PC_LOAD,
  output logic O_STACK_POP,
  output logic O_SLEEP
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  cie_pkg::cie_state_s s_q; // Registered state
  cie_pkg::cie_state_s s_d; // Next state

  // ----------------------------------------
  // Datapath helpers
  // ----------------------------------------
  logic [7:0] fval; // Addressed file register
  logic [8:0] diff; // Full subtract with borrow
  logic [4:0] ndiff; // Low nibble subtract
  logic [7:0] res; // Result of rotate or subtract
  logic res_c; // Carry from rotate or subtract
  logic go; // Instruction really executes
  logic presc_wrap; // Prescaler rolls over

  // Operand and arithmetic results
  // Rotates and subtract share one result and carry path
  always_comb
  begin
    fval = s_q.rf[I_INSTR.faddr];
    // Borrow shows as bit 8 set
    diff = {1'b0, fval} - {1'b0, s_q.w};
    ndiff = {1'b0, fval[3:0]} - {1'b0, s_q.w[3:0]};
    res = 8'h00;
    res_c = s_q.flags.carry_flag;
    unique case (I_INSTR.op)
      cie_pkg::OP_ROTATE_LEFT_CARRY:
      begin
        // Old carry into bit 0, bit 7 out
        res = {fval[6:0], s_q.flags.carry_flag};
        res_c = fval[7];
      end
      cie_pkg::OP_ROTATE_RIGHT_CARRY:
      begin
        // Old carry into bit 7, bit 0 out
        res = {s_q.flags.carry_flag, fval[7:1]};
        res_c = fval[0];
      end
      cie_pkg::OP_SUBTRACT_ACC_FROM_FILE:
      begin
        res = diff[7:0];
        res_c = ~diff[8];
      end
      default:
      begin
        res = 8'h00;
        res_c = s_q.flags.carry_flag;
      end
    endcase
  end

  // Executes when valid, awake and not being discarded
  assign go = I_INSTR_VALID && !s_q.sleep && !s_q.flush;
  // Prescaler at its top value this cycle
  assign presc_wrap = (s_q.presc == `CIE_PRESC_MAX);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Later assignments win: software access first, then hardware
  // events, then the executing instruction, so an instruction beats
  // a software write and an event beats a read clear.
  always_comb
  begin
    s_d = s_q;
    // Pulses and read data drop unless set below
    s_d.pc_load = 1'b0;
    s_d.pop = 1'b0;
    s_d.rdata = 8'h00;

    // Watchdog prescaler and counter
    s_d.presc = s_q.presc + 8'h01;
    if (presc_wrap)
    begin
      s_d.watchdog_counter = s_q.watchdog_counter + 8'h01;
    end

    // Software writes
    if (I_WR)
    begin
      if (I_ADDR[`CIE_FILE_BIT])
      begin
        // Direct preload of a file register
        s_d.rf[I_ADDR[4:0]] = I_WDATA;
      end
      else
      begin
        unique case (I_ADDR)
          `CIE_OFF_W: s_d.w = I_WDATA;
          `CIE_OFF_OPT: s_d.option = I_WDATA;
          `CIE_OFF_MASK: s_d.mask = I_WDATA;
          default: s_d.mask = s_d.mask; // Unmapped: ignored
        endcase
      end
    end

    // Software reads; event status clears on read
    if (I_RD)
    begin
      if (I_ADDR[`CIE_FILE_BIT])
      begin
        s_d.rdata = s_q.rf[I_ADDR[4:0]];
      end
      else
      begin
        unique case (I_ADDR)
          `CIE_OFF_W: s_d.rdata = s_q.w;
          `CIE_OFF_OPT: s_d.rdata = s_q.option;
          `CIE_OFF_FLAGS: s_d.rdata = {2'b00, s_q.flags};
          `CIE_OFF_EVT:
          begin
            s_d.rdata = s_q.evt;
            s_d.evt = 8'h00;
          end
          `CIE_OFF_MASK: s_d.rdata = s_q.mask;
          `CIE_OFF_WDT: s_d.rdata = s_q.watchdog_counter;
          `CIE_OFF_PRESC: s_d.rdata = s_q.presc;
          default: s_d.rdata = 8'h00; // Unmapped reads zero
        endcase
      end
    end

    // Watchdog overflow event
    if (presc_wrap && (s_q.watchdog_counter == `CIE_WDT_MAX))
    begin
      s_d.evt[`CIE_EV_WDT] = 1'b1;
    end

    // Wake leaves the halted state
    if (s_q.sleep && I_WAKE)
    begin
      s_d.sleep = 1'b0;
    end

    // Discarded slot after a literal return
    if (s_q.flush && I_INSTR_VALID)
    begin
      s_d.flush = 1'b0;
      s_d.evt[`CIE_EV_DISC] = 1'b1;
    end

    // Instruction execution
    if (go)
    begin
      unique case (I_INSTR.op)
        cie_pkg::OP_NOP:
        begin
          s_d.flush = 1'b0;
        end
        cie_pkg::OP_LOAD_OPTION:
        begin
          // Flags untouched
          s_d.option = s_q.w;
        end
        cie_pkg::OP_RETURN_WITH_LITERAL:
        begin
          // Flags untouched; next fetched word is dropped
          s_d.w = I_INSTR.lit;
          s_d.pc = I_STACK_TOP;
          s_d.pc_load = 1'b1;
          s_d.pop = 1'b1;
          s_d.flush = 1'b1;
          s_d.evt[`CIE_EV_RET] = 1'b1;
        end
        cie_pkg::OP_SLEEP:
        begin
          // Clear wins over the free-running count
          s_d.watchdog_counter = 8'h00;
          s_d.presc = 8'h00;
          s_d.flags.timeout_flag_n = 1'b1;
          s_d.flags.powerdown_flag_n = 1'b0;
          s_d.sleep = 1'b1;
          s_d.evt[`CIE_EV_SLEEP] = 1'b1;
        end
        cie_pkg::OP_ROTATE_LEFT_CARRY,
        cie_pkg::OP_ROTATE_RIGHT_CARRY:
        begin
          // Only carry changes
          s_d.flags.carry_flag = res_c;
          if (I_INSTR.dest)
          begin
            s_d.rf[I_INSTR.faddr] = res;
          end
          else
          begin
            s_d.w = res;
          end
        end
        cie_pkg::OP_SUBTRACT_ACC_FROM_FILE:
        begin
          // Carry flags follow the no-borrow convention
          s_d.flags.carry_flag = res_c;
          s_d.flags.digit_carry_flag = ~ndiff[4];
          s_d.flags.zero_flag = (res == 8'h00);
          if (I_INSTR.dest)
          begin
            s_d.rf[I_INSTR.faddr] = res;
          end
          else
          begin
            s_d.w = res;
          end
        end
        default:
        begin
          // Unused operation code: ignored like a no-op
        end
      endcase
    end
  end

  // ----------------------------------------
  // State register, synchronous reset
  // ----------------------------------------
  // Reset values come from the shared constants
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RESET)
    begin
      s_q <= '0;
      s_q.w <= `CIE_RST_W;
      s_q.option <= `CIE_RST_OPT;
      s_q.flags <= `CIE_RST_FLAGS;
      s_q.mask <= `CIE_RST_MASK;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Read data stand for one cycle only
  assign O_RDATA = s_q.rdata;

  // Level interrupt from unmasked sticky events
  assign O_IRQ = |(s_q.evt & s_q.mask);

  // Architectural state seen by the core
  assign O_W = s_q.w;
  assign O_OPTION = s_q.option;
  assign O_FLAGS = s_q.flags;

  // Return address with its one-cycle pulses
  assign O_PC = s_q.pc;
  assign O_PC_LOAD = s_q.pc_load;
  assign O_STACK_POP = s_q.pop;
  assign O_SLEEP = s_q.sleep;

endmodule

// ==== rtl/cie_pkg.sv ====
// Types for the instruction subset execution block
package cie_pkg;

  // ----------------------------------------
  // Operations the core may present
  // ----------------------------------------
  typedef enum logic [2:0] {
    OP_NOP,
    OP_LOAD_OPTION,
    OP_RETURN_WITH_LITERAL,
    OP_SLEEP,
    OP_ROTATE_LEFT_CARRY,
    OP_ROTATE_RIGHT_CARRY,
    OP_SUBTRACT_ACC_FROM_FILE
  } cie_op_e;

  // Decoded instruction
  typedef struct packed {
    cie_op_e op;
    logic dest;
    logic [4:0] faddr;
    logic [7:0] lit;
  } cie_instr_s;

  // Status flags, packed as in the flags register
  typedef struct packed {
    logic pin_change_wakeup_flag;
    logic timeout_flag_n;
    logic powerdown_flag_n;
    logic zero_flag;
    logic digit_carry_flag;
    logic carry_flag;
  } cie_flags_s;

  // Whole state of the execution block
  typedef struct packed {
    logic [7:0] w;
    logic [7:0] option;
    cie_flags_s flags;
    logic [31:0][7:0] rf;
    logic [7:0] watchdog_counter;
    logic [7:0] presc;
    logic sleep;
    logic flush;
    logic [7:0] evt;
    logic [7:0] mask;
    logic [7:0] rdata;
    logic [8:0] pc;
    logic pc_load;
    logic pop;
  } cie_state_s;

endpackage

// ==== test/cie_exec_props.sv ====
// Assertion checker for the instruction subset execution block
`timescale 1ns/1ns
module cie_exec_props (
  input logic I_CLK_SYS,
  input logic I_RESET,
  input cie_pkg::cie_instr_s I_INSTR,
  input logic I_INSTR_VALID,
  input logic [8:0] I_STACK_TOP,
  input logic I_WAKE,
  input logic I_WR,
  input logic [7:0] O_W,
  input logic [7:0] O_OPTION,
  input cie_pkg::cie_flags_s O_FLAGS,
  input logic [8:0] O_PC,
  input logic O_PC_LOAD,
  input logic O_STACK_POP,
  input logic O_SLEEP
);
  // ----------------------------------------
  // Accepted instruction
  // ----------------------------------------
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RESET);
  cie_pkg::cie_op_e op;
  assign op = I_INSTR.op;
  // Return taken and its slot not yet used
  logic pend_q;
  // Slot after a return is never taken
  wire take = I_INSTR_VALID && !O_SLEEP && !pend_q;
  // Tracks the pending discard as the core does
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RESET)
      pend_q <= 1'b0;
    else if (take && op == cie_pkg::OP_RETURN_WITH_LITERAL)
      pend_q <= 1'b1;
    else if (I_INSTR_VALID)
      pend_q <= 1'b0;
  end
  // Literal return taken
  sequence ret_s;
    take && op == cie_pkg::OP_RETURN_WITH_LITERAL;
  endsequence
  // Instruction offered in the slot after it
  sequence disc_s;
    ret_s ##1 (I_INSTR_VALID && !I_WR);
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  opt_load_a: assert property (
    take && op == cie_pkg::OP_LOAD_OPTION
    |=> O_OPTION == $past(O_W) && $stable(O_FLAGS))
    else $error("option load wrong");
  ret_load_a: assert property (
    ret_s |=> O_W == $past(I_INSTR.lit) && O_PC == $past(I_STACK_TOP)
    && O_PC_LOAD && O_STACK_POP && $stable(O_FLAGS))
    else $error("literal return wrong");
  ret_skip_a: assert property (
    disc_s |=> $stable(O_W) && $stable(O_OPTION) && $stable(O_FLAGS))
    else $error("slot after return executed");
  sleep_in_a: assert property (
    take && op == cie_pkg::OP_SLEEP && !I_WAKE |=> O_SLEEP
    && O_FLAGS.timeout_flag_n && !O_FLAGS.powerdown_flag_n
    && $stable(O_FLAGS.pin_change_wakeup_flag))
    else $error("sleep entry wrong");
  core_halt_a: assert property (
    O_SLEEP && !I_WAKE && !I_WR
    |=> O_SLEEP && $stable(O_W) && $stable(O_OPTION))
    else $error("core ran while asleep");
  rot_flags_a: assert property (
    take && op inside {cie_pkg::OP_ROTATE_LEFT_CARRY,
    cie_pkg::OP_ROTATE_RIGHT_CARRY}
    |=> O_FLAGS[5:1] == $past(O_FLAGS[5:1]))
    else $error("rotate touched other flags");
  sub_zero_a: assert property (
    take && op == cie_pkg::OP_SUBTRACT_ACC_FROM_FILE && !I_INSTR.dest
    |=> O_FLAGS.zero_flag == (O_W == 8'h00))
    else $error("subtract zero flag wrong");
  file_dest_a: assert property (
    take && op >= cie_pkg::OP_ROTATE_LEFT_CARRY && I_INSTR.dest && !I_WR
    |=> $stable(O_W))
    else $error("file result reached accumulator");
endmodule

bind cie_exec cie_exec_props u_props (.I_CLK_SYS, .I_RESET, .I_INSTR,
  .I_INSTR_VALID, .I_STACK_TOP, .I_WAKE, .I_WR, .O_W, .O_OPTION, .O_FLAGS,
  .O_PC, .O_PC_LOAD, .O_STACK_POP, .O_SLEEP);

// ==== test/tb.sv ====
// Self-checking bench for the instruction subset execution block
`timescale 1ns/1ns
module tb;
  logic I_CLK_SYS, I_RESET, I_INSTR_VALID, I_WAKE, I_WR, I_RD, O_IRQ;
  logic O_PC_LOAD, O_STACK_POP, O_SLEEP;
  cie_pkg::cie_instr_s I_INSTR;
  cie_pkg::cie_flags_s O_FLAGS;
  logic [8:0] I_STACK_TOP, O_PC;
  logic [5:0] I_ADDR;
  logic [7:0] I_WDATA, O_RDATA, O_W, O_OPTION, f, w, r;
  // Subtract operands: file value, accumulator value
  logic [7:0] fv [4] = '{8'h05, 8'h10, 8'h01, 8'h33};
  logic [7:0] wv [4] = '{8'h05, 8'h01, 8'h02, 8'h11};
  int num_errors = 0;
  int n_compared = 0;
  int i;
  cie_exec u_dut (.I_CLK_SYS, .I_RESET, .I_INSTR, .I_INSTR_VALID,
    .I_STACK_TOP, .I_WAKE, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA,
    .O_IRQ, .O_W, .O_OPTION, .O_FLAGS, .O_PC, .O_PC_LOAD, .O_STACK_POP,
    .O_SLEEP);
  // ----------------------------------------
  // Clock and access tasks
  // ----------------------------------------
  initial
  begin
    I_CLK_SYS = 1'b0;
    forever #25 I_CLK_SYS = ~I_CLK_SYS;
  end
  // Compare seen against expected
  task chk(input logic [8:0] s, input logic [8:0] e);
    n_compared++;
    if (s !== e)
    begin
      num_errors++;
      $display("Error at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  // One-cycle register write
  task wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge I_CLK_SYS);
    I_ADDR <= a;
    I_WDATA <= d;
    I_WR <= 1'b1;
    @(posedge I_CLK_SYS);
    I_WR <= 1'b0;
  endtask
  // One-cycle register read, data in the cycle after
  task rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge I_CLK_SYS);
    I_ADDR <= a;
    I_RD <= 1'b1;
    @(posedge I_CLK_SYS);
    I_RD <= 1'b0;
    #1 chk(O_RDATA, e);
  endtask
  // One instruction cycle, literal zero
  task exe(input cie_pkg::cie_op_e o, input logic d, input logic [4:0] a);
    @(posedge I_CLK_SYS);
    I_INSTR <= '{o, d, a, 8'h00};
    I_INSTR_VALID <= 1'b1;
    @(posedge I_CLK_SYS);
    I_INSTR_VALID <= 1'b0;
    #1;
  endtask
  // Verdict and end of run
  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {I_RESET, I_INSTR_VALID, I_WAKE, I_WR, I_RD} = 5'b10000;
    I_INSTR = '0;
    I_STACK_TOP = '0;
    I_ADDR = '0;
    I_WDATA = '0;
    repeat (10) @(posedge I_CLK_SYS);
    I_RESET <= 1'b0;
    rd(6'h01, 8'hff);
    rd(6'h02, 8'h18);
    rd(6'h10, 8'h00);
    $display("reset test done");
    wr(6'h00, 8'h5a);
    exe(cie_pkg::OP_LOAD_OPTION, 1'b0, 5'h00);
    rd(6'h01, 8'h5a);
    chk(O_OPTION, 8'h5a);
    rd(6'h02, 8'h18);
    wr(6'h04, 8'h02);
    // Return, then an option load in the slot after it
    @(posedge I_CLK_SYS);
    I_STACK_TOP <= 9'h1a5;
    I_INSTR <= '{cie_pkg::OP_RETURN_WITH_LITERAL, 1'b0, 5'h00, 8'hff};
    I_INSTR_VALID <= 1'b1;
    @(posedge I_CLK_SYS);
    I_INSTR <= '{cie_pkg::OP_LOAD_OPTION, 1'b0, 5'h00, 8'h00};
    #1 chk(O_W, 8'hff);
    chk(O_PC, 9'h1a5);
    chk({O_PC_LOAD, O_STACK_POP}, 2'b11);
    @(posedge I_CLK_SYS);
    I_INSTR_VALID <= 1'b0;
    #1 chk({O_PC_LOAD, O_STACK_POP}, 2'b00);
    rd(6'h01, 8'h5a);
    rd(6'h02, 8'h18);
    chk(O_IRQ, 1'b1);
    rd(6'h03, 8'h0a);
    chk(O_IRQ, 1'b0);
    $display("option and return tests done");
    // Let the watchdog counter leave zero before sleeping
    repeat (300) @(posedge I_CLK_SYS);
    rd(6'h05, 8'h01);
    exe(cie_pkg::OP_SLEEP, 1'b0, 5'h00);
    chk(O_SLEEP, 1'b1);
    rd(6'h05, 8'h00);
    rd(6'h06, 8'h03);
    rd(6'h02, 8'h10);
    chk(O_FLAGS, 6'h10);
    chk(O_IRQ, 1'b0);
    exe(cie_pkg::OP_LOAD_OPTION, 1'b0, 5'h00);
    rd(6'h01, 8'h5a);
    @(posedge I_CLK_SYS);
    I_WAKE <= 1'b1;
    @(posedge I_CLK_SYS);
    I_WAKE <= 1'b0;
    #1;
    for (i = 0; i < 8 && O_SLEEP; i++)
      @(posedge I_CLK_SYS) #1;
    chk(O_SLEEP, 1'b0);
    rd(6'h03, 8'h01);
    $display("sleep test done");
    wr(6'h23, 8'h81);
    exe(cie_pkg::OP_ROTATE_LEFT_CARRY, 1'b1, 5'h03);
    rd(6'h23, 8'h02);
    rd(6'h02, 8'h11);
    exe(cie_pkg::OP_ROTATE_RIGHT_CARRY, 1'b0, 5'h03);
    chk(O_W, 8'h81);
    rd(6'h23, 8'h02);
    rd(6'h02, 8'h10);
    $display("rotate test done");
    for (i = 0; i < 4; i++)
    begin
      f = fv[i];
      w = wv[i];
      r = f - w;
      wr(6'h20, f);
      wr(6'h00, w);
      exe(cie_pkg::OP_SUBTRACT_ACC_FROM_FILE, i[0], 5'h00);
      rd(6'h20, i[0] ? r : f);
      chk(O_W, i[0] ? w : r);
      rd(6'h02, {5'b00010, r == 8'h00, f[3:0] >= w[3:0], f >= w});
    end
    $display("subtract test done");
    end_of_test;
  end
endmodule
